// ==== src/sram_host.sv ====
// Controller that drives a 16K x 4 asynchronous static memory.
// Assumes the memory shares one 4-bit data bus and has no clock.
`timescale 1ns/1ps
`default_nettype none
module sram_host
   import sram_host_pkg::*;
#(
   parameter sram_host_pkg::grade_t GRADE = sram_host_pkg::GRADE_FAST // Speed grade targeted.
) (
   input  wire logic                        mclk,
   input  wire logic                        srst,
   input  wire logic                        req_valid,
   input  wire sram_host_pkg::req_t         req,
   output logic                             req_ready,
   output sram_host_pkg::rsp_t              rsp,
   output logic                             select_n,
   output logic                             write_strobe_n,
   output logic [sram_host_pkg::ADDR_W-1:0] word_address,
   output logic [sram_host_pkg::DATA_W-1:0] data_out,
   output logic                             data_oe_n,
   input  wire logic [sram_host_pkg::DATA_W-1:0] data_in
);
   import sram_host_pkg::*;

   // -----------------------------------------------------------------
   // Cycle counts for the selected grade
   // -----------------------------------------------------------------
   // Read waits the access time for the word to reach the pins, then three
   // more cycles while it walks through the synchroniser stages; taking it
   // any earlier would latch whatever the bus showed before the access ended.
   localparam int RD_CYC  = cyc_up(ACCESS_NS[GRADE]) + 3;
   localparam int OFF_CYC = cyc_up(OFF_NS[GRADE]);
   localparam int WP_CYC  = cyc_up(WRITE_PULSE_NS[GRADE]);
   localparam int DS_CYC  = cyc_up(DATA_SETUP_NS[GRADE]);
   // Strobe low holds for pulse width and for strobe-off plus data setup.
   localparam int LOW_CYC = (WP_CYC > OFF_CYC + DS_CYC) ? WP_CYC : OFF_CYC + DS_CYC;
   localparam int GAP_CYC = cyc_up(WRITE_CYCLE_NS[GRADE]) > LOW_CYC ?
                            cyc_up(WRITE_CYCLE_NS[GRADE]) - LOW_CYC : 1;
   localparam int REC_CYC = cyc_up(OFF_NS[GRADE] > ON_AFTER_WRITE_NS ?
                                   OFF_NS[GRADE] : ON_AFTER_WRITE_NS);
   localparam logic [3:0] RD_C  = 4'(RD_CYC);
   localparam logic [3:0] OFF_C = 4'(OFF_CYC);
   localparam logic [3:0] LOW_C = 4'(LOW_CYC);
   localparam logic [3:0] GAP_C = 4'(GAP_CYC);
   localparam logic [3:0] REC_C = 4'(REC_CYC);

   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WSTROBE, ST_WDATA, ST_WGAP, ST_RECOVER} state_t;

   state_t     state;  // Sequencer state.
   logic [3:0] count;  // Cycles since the count last restarted; runs on from ST_WSTROBE into ST_WDATA.
   logic [DATA_W-1:0] sync1; // First synchroniser stage, read only by sync2.
   logic [DATA_W-1:0] sync2; // Second stage.
   logic [DATA_W-1:0] sync3; // Third stage; data used once 2 and 3 agree.

   // -----------------------------------------------------------------
   // Read data synchroniser
   // -----------------------------------------------------------------
   // The memory data is asynchronous to mclk, so it passes three stages.
   always_ff @(posedge mclk) begin
      if (srst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= data_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   // Address only changes in idle with both controls high, which keeps
   // transient addresses out of the array.
   always_ff @(posedge mclk) begin
      if (srst) begin
         state          <= ST_IDLE;
         count          <= '0;
         select_n       <= 1'b1; // Deselected: memory floats and stands by.
         write_strobe_n <= 1'b1;
         word_address   <= '0;
         data_out       <= '0;
         data_oe_n      <= 1'b1;
         req_ready      <= 1'b0;
         rsp            <= '0;
      end else begin
         rsp.done <= 1'b0;
         count    <= count + 4'h1;
         case (state)
            ST_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready    <= 1'b0;
                  word_address <= req.address;
                  data_out     <= req.data;
                  count        <= 4'h1;
                  select_n     <= 1'b0;
                  if (req.write) begin
                     // Strobe falls with select, so the memory never drives.
                     write_strobe_n <= 1'b0;
                     state          <= ST_WSTROBE;
                  end else begin
                     state <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               // The word is taken only once the last two stages agree, so a
               // bit caught mid-change is never handed back as read data.
               if (count >= RD_C && sync2 == sync3) begin
                  rsp.data <= sync3;
                  rsp.done <= 1'b1;
                  select_n <= 1'b1;
                  count    <= 4'h1;
                  state    <= ST_RECOVER;
               end
            end
            ST_WSTROBE: begin
               // Bus stays released until the strobe-off delay passes.
               if (count == OFF_C) begin
                  data_oe_n <= 1'b0;
                  state     <= ST_WDATA;
               end
            end
            ST_WDATA: begin
               if (count == LOW_C) begin
                  // Both controls rise together; data and address held past it.
                  write_strobe_n <= 1'b1;
                  select_n       <= 1'b1;
                  count          <= 4'h1;
                  state          <= ST_WGAP;
               end
            end
            ST_WGAP: begin
               data_oe_n <= 1'b1;
               if (count >= GAP_C) begin
                  count <= 4'h1;
                  state <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               // Memory output may still be turning off; hold the bus idle.
               if (count >= REC_C) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence write_start_s;
      $fell(write_strobe_n);
   endsequence

   // End of a write; a strobe forced high by reset does not count as one.
   sequence write_end_s;
      $rose(write_strobe_n) && !$past(srst);
   endsequence

   // The host starts to drive the shared data bus.
   sequence drive_start_s;
      $fell(data_oe_n);
   endsequence

   property strobe_needs_select_p;
      @(posedge mclk) disable iff (srst) !write_strobe_n |-> !select_n;
   endproperty
   strobe_select_a: assert property (strobe_needs_select_p)
      else $error("Strobe low without select.");

   addr_stable_a: assert property (@(posedge mclk) disable iff (srst)
      (!select_n && !write_strobe_n) |=> $stable(word_address) || write_strobe_n)
      else $error("Address moved during write.");

   no_contend_a: assert property (@(posedge mclk) disable iff (srst)
      write_start_s |-> data_oe_n [*1])
      else $error("Data driven at strobe fall.");

   pulse_width_a: assert property (@(posedge mclk) disable iff (srst)
      write_start_s |-> !write_strobe_n [*2])
      else $error("Write pulse too short.");

   data_setup_a: assert property (@(posedge mclk) disable iff (srst)
      write_end_s |-> $past(!data_oe_n))
      else $error("Write data not set up.");

   read_len_a: assert property (@(posedge mclk) disable iff (srst)
      (state == ST_IDLE && req_valid && req_ready && !req.write) |=> !select_n [*4])
      else $error("Read select too short.");

   deselect_strobe_a: assert property (@(posedge mclk) disable iff (srst)
      select_n |-> write_strobe_n)
      else $error("Deselected with strobe low.");

   select_recover_a: assert property (@(posedge mclk) disable iff (srst)
      $rose(select_n) |=> select_n)
      else $error("Reselected too soon.");

   // The host starts to drive only inside a write, while the memory keeps its outputs off.
   drive_inside_a: assert property (@(posedge mclk) disable iff (srst)
      drive_start_s |-> !select_n && !write_strobe_n)
      else $error("Bus driven outside a write.");

   // Write data must still stand at the edge that ends the write.
   data_hold_a: assert property (@(posedge mclk) disable iff (srst)
      write_end_s |-> !data_oe_n && $stable(data_out))
      else $error("Write data not held to write end.");

   // No new write may start before the write cycle time has passed.
   write_spacing_a: assert property (@(posedge mclk) disable iff (srst)
      write_end_s |=> write_strobe_n [*2])
      else $error("Write cycles too close.");

   // A request is only offered while the memory pins are idle and released.
   idle_pins_a: assert property (@(posedge mclk) disable iff (srst)
      req_ready |-> select_n && write_strobe_n && data_oe_n)
      else $error("Ready while the bus is busy.");

endmodule // sram_host
`default_nettype wire

// ==== src/sram_host_pkg.sv ====
// Constants, types and timing counts for the static memory controller.
// Assumes a 25 MHz mclk; every delay below is converted to whole cycles.
//
// Function
// - Master drives data after strobe-off delay.
// - Address changes only with a control high.
// - Strobe, select low 30 ns; cycle 40 ns.
// - Data valid 20 ns before terminating edge.
// - Address settled 30 ns before write end.
`default_nettype none
package sram_host_pkg;

   // -----------------------------------------------------------------
   // Geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 14; // Word address width.
   localparam int DATA_W = 4;  // Word width.

   // -----------------------------------------------------------------
   // Clock and speed grades
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40; // Period of mclk.

   typedef enum logic [1:0] {GRADE_FAST, GRADE_MID, GRADE_SLOW} grade_t;

   // Figures per grade, in ns.
   localparam int ACCESS_NS [3]     = '{45, 55, 70}; // Address and select access.
   localparam int OFF_NS [3]        = '{15, 20, 25}; // Strobe or deselect to output off.
   localparam int WRITE_PULSE_NS [3] = '{30, 40, 50}; // Strobe and select low time.
   localparam int WRITE_CYCLE_NS [3] = '{40, 50, 60}; // Write cycle time.
   localparam int DATA_SETUP_NS [3]  = '{20, 25, 30}; // Data setup to end of write.
   localparam int ON_AFTER_WRITE_NS = 5;              // Output active after write end.

   // Every time rounds up to whole cycles, least and longest alike, never below one cycle.
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // -----------------------------------------------------------------
   // Request and answer carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic              write;   // High for a write.
      logic [ADDR_W-1:0] address; // Word address.
      logic [DATA_W-1:0] data;    // Write data.
   } req_t;

   typedef struct packed {
      logic              done;    // One-cycle read completion pulse; writes give none.
      logic [DATA_W-1:0] data;    // Read data, valid with done.
   } rsp_t;

endpackage
`default_nettype wire

// ==== testbench/sram_host_test.sv ====
// Self-checking bench for the static memory controller.
// Assumes the memory model on the pins and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sram_host_test;
   import sram_host_pkg::*;
   localparam int RD_LAT = (ACCESS_NS[0] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 3; // Accept to done.
   logic              mclk = 1'h0, srst = 1'h1, req_valid = 1'h0; // Clock, reset, request.
   req_t              req = '0;                                   // Request fields.
   logic              req_ready, select_n, write_strobe_n, data_oe_n, prev_w = 1'h0;
   rsp_t              rsp;                                        // Read answer.
   logic [ADDR_W-1:0] word_address, prev_addr;
   logic [DATA_W-1:0] data_out, data_in;
   int                num_errors = 0, tests_run = 0, cycles = 0;

   always #20 mclk = ~mclk;

   sram_host #(.GRADE(GRADE_FAST)) i_sram_host (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp(rsp), .select_n(select_n), .write_strobe_n(write_strobe_n),
      .word_address(word_address), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in));
   sram_model #(.GRADE(GRADE_FAST)) i_sram_model (.ctl_n({select_n, write_strobe_n}),
      .word_address(word_address), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in));

   task automatic check(input string name, input logic [18:0] seen, input logic [18:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchers: no bus fight, no address move inside a write, and a cycle ceiling.
   always @(posedge mclk) begin
      if (!srst) check("bus fight", !data_oe_n && i_sram_model.q_on, 1'h0);
      if (!srst && prev_w && !select_n && !write_strobe_n) check("write address", word_address, prev_addr);
      prev_w <= !select_n && !write_strobe_n;
      prev_addr <= word_address;
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         results();
      end
   end

   // One request; a read reports the cycles from acceptance to its answer.
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output int lat);
      int n;
      n = 0;
      lat = 0;
      @(posedge mclk);
      req_valid <= 1'h1;
      req <= '{write: wr, address: a, data: d};
      do begin @(posedge mclk); n++; end while (req_ready !== 1'h1 && n < 50);
      req_valid <= 1'h0;
      if (!wr) do begin @(posedge mclk); #1; lat++; end while (rsp.done !== 1'h1 && lat < 50);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      int lat;
      access(1'h0, a, 4'h0, lat);
      check("read latency", 19'(lat), 19'(RD_LAT));
      check("read data", rsp.data, exp);
      @(posedge mclk);
      #1;
      check("done width", rsp.done, 1'h0);
   endtask

   task automatic test_reset();
      repeat (4) @(posedge mclk);
      #1;
      check("reset pins", {select_n, write_strobe_n, data_oe_n, req_ready}, 4'hE);
      repeat (4) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      #1;
      check("ready after reset", req_ready, 1'h1);
   endtask

   // Corner addresses written back to back, then read back to back.
   task automatic test_write_read();
      logic [ADDR_W-1:0] a [4] = '{14'h0000, 14'h3FFF, 14'h2AAA, 14'h1555};
      logic [DATA_W-1:0] d [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
      int lat;
      foreach (a[i]) access(1'h1, a[i], d[i], lat);
      foreach (a[i]) rd(a[i], d[i]);
      access(1'h1, a[1], 4'h3, lat);
      rd(a[1], 4'h3);
   endtask

   // Reset in mid-read must free the pins and keep the stored words.
   task automatic test_abort();
      @(posedge mclk);
      req_valid <= 1'h1;
      req <= '{write: 1'h0, address: 14'h2AAA, data: 4'h0};
      @(posedge mclk);
      req_valid <= 1'h0;
      @(posedge mclk);
      srst <= 1'h1;
      @(posedge mclk);
      srst <= 1'h0;
      #1;
      check("abort pins", {select_n, write_strobe_n, data_oe_n}, 3'h7);
      repeat (3) @(posedge mclk);
      #1;
      check("standby drivers", {select_n, i_sram_model.q_on}, 2'h2);
      rd(14'h2AAA, 4'hF);
   endtask

   initial begin
      test_reset();
      test_write_read();
      test_abort();
      results();
   end
endmodule // sram_host_test
`default_nettype wire

// ==== testbench/sram_model.sv ====
// Behavioural model of the 16K x 4 static memory on the controller's pins.
// Assumes the controller drives the pins from mclk; delays are in ns.
`timescale 1ns/1ps
`default_nettype none
module sram_model
   import sram_host_pkg::*;
#(
   parameter sram_host_pkg::grade_t GRADE = sram_host_pkg::GRADE_FAST // Speed grade.
) (
   input  wire logic [1:0]                       ctl_n,
   input  wire logic [sram_host_pkg::ADDR_W-1:0] word_address,
   input  wire logic [sram_host_pkg::DATA_W-1:0] data_out,
   input  wire logic                             data_oe_n,
   output logic      [sram_host_pkg::DATA_W-1:0] data_in
);
   import sram_host_pkg::*;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // One word per address.
   logic [DATA_W-1:0] q = '0;                 // Word at the outputs.
   logic              q_on = 1'h0;            // Output drivers on.
   logic [DATA_W-1:0] last = '0;              // Last driven bus level.
   logic [ADDR_W-1:0] wa;                     // Address of the write.
   logic [DATA_W-1:0] wd;                     // Data of the write.
   wire               writing;                // Both controls low.
   assign writing = !ctl_n[1] && !ctl_n[0];

   // Read mode seen through an inertial delay, so a zero-width pass through read
   // mode while both controls move at one edge never turns the drivers on.
   wire               read_mode;              // Select low, strobe high.
   wire               read_on;                // Read mode held for the turn-on delay.
   assign read_mode = (ctl_n === 2'h1);
   assign #(ON_AFTER_WRITE_NS) read_on = read_mode;

   // Drivers: bit 1 is select, bit 0 the strobe. A late turn-off is the worst legal case.
   always @(ctl_n or read_on) begin
      if (ctl_n[1] !== 1'h0) q_on <= #(OFF_NS[GRADE]) 1'h0;
      else if (ctl_n[0] !== 1'h1) q_on <= 1'h0;
      else if (read_on === 1'h1) q_on <= 1'h1;
   end

   // Old word held, then garbage, then the new word at full access time.
   always @(word_address or ctl_n) begin
      q <= #5 ~q;
      q <= #(ACCESS_NS[GRADE]) mem[word_address];
   end

   // The write opens at the later falling control and lands at the first rising one.
   always @* if (writing) begin
      wa = word_address;
      wd = data_in;
   end
   always @(negedge writing) mem[wa] = wd;

   // Bus level: a fight reads unknown, a released bus shows no stale value.
   always @(data_out or q or data_oe_n or q_on) begin
      if (!data_oe_n) last = data_out;
      else if (q_on) last = q;
   end
   always @* begin
      if (!data_oe_n && q_on) data_in = 4'hX;
      else if (!data_oe_n) data_in = data_out;
      else if (q_on) data_in = q;
      else data_in = ~last;
   end
endmodule // sram_model
`default_nettype wire
